// >>> verif/reset_switch_model.sv
// Model of the outside reset/test switch and the monitoring contacts
`timescale 1ns/1ps
`default_nettype none

module reset_switch_model (
  input  wire logic       clk,
  input  wire logic       pressed,
  input  wire logic       monMode,
  input  wire logic [7:0] gapLen,
  input  wire logic [1:0] outs,
  output var  logic       resetTestIn
);
  logic [1:0] outsPrev = 2'h0;
  logic [7:0] gapCnt   = 8'h0;

  // Contacts swing open for gapLen cycles after each output change
  always_ff @(posedge clk) begin
    outsPrev <= outs;
    if (outs != outsPrev) gapCnt <= gapLen;
    else if (gapCnt != 8'h0) gapCnt <= gapCnt - 8'h1;
  end

  // Without monitoring the line is tied to supply; only the switch opens it
  assign resetTestIn = !pressed && !(monMode && gapCnt != 8'h0);
endmodule

`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the screen reset/test monitor
`timescale 1ns/1ps
`default_nettype none

module tb;
  // --------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------
  logic             clk        = 1'b0;
  logic             rst_b      = 1'b0;
  logic             psel       = 1'b0;
  logic             penable    = 1'b0;
  logic             pwrite     = 1'b0;
  logic [3:0]       paddr      = 4'h0;
  logic [31:0]      pwdata     = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             resetTestIn;
  logic             beamTop    = 1'b1;
  logic             beamBot    = 1'b1;
  logic [1:0]       outs;
  screen_pkg::led_s leds;
  logic             irq;
  logic             pressed    = 1'b1;
  logic             monMode    = 1'b0;
  logic [7:0]       gapLen     = 8'h5;
  logic [31:0]      rd;
  logic             slvErr;
  logic             phase;
  int               num_errors = 0;
  int               tests_run  = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // Short counts keep the run brief
  screen_monitor #(.QUARTER_CYC(40), .MON_CYC(30), .FLASH_CYC(8), .TEST_CYC(10), .CNT_W(8))
    u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .resetTestIn(resetTestIn), .beamTopClear(beamTop), .beamBotClear(beamBot),
      .safetySwitchingOutputs(outs), .leds(leds), .irq(irq));

  reset_switch_model u_switch (.clk(clk), .pressed(pressed), .monMode(monMode),
    .gapLen(gapLen), .outs(outs), .resetTestIn(resetTestIn));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits end on falling edges so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One APB transfer; no cycle count assumed, the watchdog bounds it
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd     = prdata;
    slvErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic state_is(input screen_pkg::state_e st, input logic [1:0] o);
    apb(1'b0, screen_pkg::OFF_STATUS, 32'h0);
    @(negedge clk);
    check("state", {29'h0, rd[2:0]}, {29'h0, st});
    check("outputs", {30'h0, outs}, {30'h0, o});
  endtask

  // A flashing lamp shows opposite levels one flash period apart
  task automatic flashes(input string what, input int idx);
    phase = leds[idx];
    tick(8);
    check(what, {31'h0, leds[idx] ^ phase}, 32'h1);
  endtask

  task automatic open_for(input int n);
    @(posedge clk);
    pressed <= 1'b1;
    tick(n);
  endtask

  task automatic close_line;
    @(posedge clk);
    pressed <= 1'b0;
    tick(14);
  endtask

  task automatic set_beam(input logic top, input int n);
    @(posedge clk);
    beamTop <= top;
    tick(n);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // Power up with the line open, then walk every mode
  initial begin
    tick(8);
    @(posedge clk);
    rst_b <= 1'b1;
    tick(6);
    state_is(screen_pkg::ST_LOCKOUT, 2'h0);
    flashes("lockout red", 1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, screen_pkg::OFF_INT_MASK, 32'hF);
    tick(2);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, screen_pkg::OFF_INT_STAT, 32'h0);
    check("lockout event", rd, 32'h2);
    tick(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, 4'h2, 32'h0);
    check("unmapped", {31'h0, slvErr}, 32'h1);
    tick(40);
    state_is(screen_pkg::ST_LOCKOUT, 2'h0);
    close_line();
    state_is(screen_pkg::ST_RUN, 2'h3);
    check("clear lamps", {28'h0, leds}, 32'hD);
    apb(1'b0, screen_pkg::OFF_INT_STAT, 32'h0);
    check("reset event", rd, 32'h8);
    open_for(30);
    state_is(screen_pkg::ST_RUN, 2'h3);
    close_line();
    open_for(46);
    state_is(screen_pkg::ST_TEST, 2'h0);
    check("test red", {31'h0, leds.blocked}, 32'h1);
    close_line();
    state_is(screen_pkg::ST_RUN, 2'h3);
    set_beam(1'b0, 4);
    check("blocked lamps", {28'h0, leds}, 32'h6);
    set_beam(1'b1, 4);
    apb(1'b1, screen_pkg::OFF_CTRL, 32'h2);
    monMode <= 1'b1;
    apb(1'b0, screen_pkg::OFF_CTRL, 32'h0);
    check("ctrl", rd, 32'h2);
    set_beam(1'b0, 6);
    set_beam(1'b1, 40);
    state_is(screen_pkg::ST_RUN, 2'h3);
    open_for(34);
    state_is(screen_pkg::ST_TEST, 2'h0);
    close_line();
    state_is(screen_pkg::ST_RUN, 2'h3);
    apb(1'b1, screen_pkg::OFF_CTRL, 32'h1);
    monMode <= 1'b0;
    set_beam(1'b0, 4);
    state_is(screen_pkg::ST_LATCH, 2'h0);
    set_beam(1'b1, 4);
    check("latch lamps", {30'h0, leds.blocked, leds.clear}, 32'h2);
    flashes("latch align", 3);
    open_for(46);
    state_is(screen_pkg::ST_LATCH, 2'h0);
    close_line();
    state_is(screen_pkg::ST_RUN, 2'h3);
    apb(1'b1, screen_pkg::OFF_CTRL, 32'h5);
    state_is(screen_pkg::ST_TEST, 2'h0);
    tick(14);
    state_is(screen_pkg::ST_RUN, 2'h3);
    apb(1'b1, screen_pkg::OFF_CTRL, 32'h9);
    state_is(screen_pkg::ST_LOCKOUT, 2'h0);
    open_for(46);
    state_is(screen_pkg::ST_LOCKOUT, 2'h0);
    close_line();
    state_is(screen_pkg::ST_RUN, 2'h3);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, screen_pkg::OFF_INT_STAT, 32'h0);
    check("all events", rd, 32'hF);
    give_verdict();
  end
endmodule

`default_nettype wire

// >>> verilog/open_timer.sv
// Synchroniser and open-duration timer for the reset/test input
`timescale 1ns/1ps
`default_nettype none

module open_timer #(
  parameter int CNT_W   = 25,
  parameter int QUARTER = screen_pkg::QUARTER_CYC,
  parameter int MON     = screen_pkg::MON_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic resetTestIn,
  output var  logic inClosed,
  output var  logic syncReady,
  output var  logic openQuarter,
  output var  logic openMon,
  output var  logic releasePulse
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  logic       syncA;
  logic [1:0] readyCnt;
  logic [CNT_W-1:0] openCnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA    <= 1'b0;
      inClosed <= 1'b0;
    end else begin
      syncA    <= resetTestIn;
      inClosed <= syncA;
    end
  end

  // Sampled level is meaningless until both stages have filled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readyCnt <= 2'h0;
    end else if (readyCnt != 2'(screen_pkg::SYNC_STAGES)) begin
      readyCnt <= readyCnt + 2'h1;
    end
  end
  assign syncReady = (readyCnt == 2'(screen_pkg::SYNC_STAGES));

  // ----------------------------------------------------------------
  // Open duration, saturating so a stuck-open input stays long
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      openCnt <= '0;
    end else if (inClosed || !syncReady) begin
      openCnt <= '0;
    end else if (openCnt != {CNT_W{1'b1}}) begin
      openCnt <= openCnt + CNT_W'(1);
    end
  end

  assign openQuarter = syncReady && (openCnt > CNT_W'(QUARTER));
  assign openMon     = syncReady && (openCnt > CNT_W'(MON));

  // Close after a long enough open forms the reset gesture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      releasePulse <= 1'b0;
    end else begin
      releasePulse <= openQuarter && inClosed;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/screen_monitor.sv
// Reset/test input monitor and indicator control of a light-screen receiver
//
// Behaviour
// - In run mode an open on the reset/test input longer than a quarter second starts a test cycle with both outputs off.
// - With monitoring enabled an open longer than 200 ms in run mode starts a test cycle with outputs off.
// - Control resets with CTRL_LATCH clear; a unit powers up latched (alignment lamps flashing on a clear field, outputs off) only if set when syncReady rises.
// - In lockout the red blocked lamp flashes.
// - Blocked means red on, green off, each alignment lamp showing its own beam.
// - Clear means green and both alignment lamps on, red off.
// - Latched with a clear field means red on, green off, alignment lamps flashing.
// - Only a manual reset, or a software lock command sending it to lockout, takes the unit out of latch; the operator must give the reset.
// - When latched or locked out, operating the input is a reset, not a test.
// - An open input when power is applied sends the unit to lockout.
// - Trip units need a manual reset only after lockout; latch units also after each latch, and at power-up only if CTRL_LATCH is set when syncReady rises.
`timescale 1ns/1ps
`default_nettype none

module screen_monitor #(
  parameter int QUARTER_CYC = screen_pkg::QUARTER_CYC,
  parameter int MON_CYC     = screen_pkg::MON_CYC,
  parameter int FLASH_CYC   = screen_pkg::FLASH_CYC,
  parameter int TEST_CYC    = screen_pkg::TEST_CYC,
  parameter int CNT_W       = 25
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [3:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              resetTestIn,
  input  wire logic              beamTopClear,
  input  wire logic              beamBotClear,
  output var  logic [1:0]        safetySwitchingOutputs,
  output var  screen_pkg::led_s  leds,
  output var  logic              irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  screen_pkg::state_e state_reg;
  screen_pkg::state_e state_next;
  logic        inClosed;
  logic        syncReady;
  logic        openQuarter;
  logic        openMon;
  logic        releasePulse;
  logic [1:0]  ctrl_reg;
  logic        testReq_reg;
  logic        lockReq_reg;
  logic [screen_pkg::INT_W-1:0] intStat_reg;
  logic [screen_pkg::INT_W-1:0] intMask_reg;
  logic [screen_pkg::INT_W-1:0] events;
  logic [screen_pkg::INT_W-1:0] rdClear_reg;
  logic [CNT_W-1:0] flashCnt;
  logic        flashPhase;
  logic [CNT_W-1:0] testCnt;
  logic        fieldClear;
  logic        setupPh;
  logic        accessPh;
  logic        wrAccess;
  logic        rdStatAccess;

  assign fieldClear = beamTopClear && beamBotClear;
  assign setupPh    = psel && !penable;
  assign accessPh   = psel && penable && pready;
  assign wrAccess   = accessPh && pwrite;

  // Address decode, used only for the slave error response
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == screen_pkg::OFF_CTRL) || (a == screen_pkg::OFF_STATUS) ||
             (a == screen_pkg::OFF_INT_STAT) || (a == screen_pkg::OFF_INT_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Input timing
  // ----------------------------------------------------------------
  open_timer #(
    .CNT_W   (CNT_W),
    .QUARTER (QUARTER_CYC),
    .MON     (MON_CYC)
  ) uTimer (
    .clk          (clk),
    .rst_b        (rst_b),
    .resetTestIn  (resetTestIn),
    .inClosed     (inClosed),
    .syncReady    (syncReady),
    .openQuarter  (openQuarter),
    .openMon      (openMon),
    .releasePulse (releasePulse)
  );

  // ----------------------------------------------------------------
  // Flash divider: one-cycle enable toggles the flash phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flashCnt   <= '0;
      flashPhase <= 1'b0;
    end else if (flashCnt == CNT_W'(FLASH_CYC - 1)) begin
      flashCnt   <= '0;
      flashPhase <= !flashPhase;
    end else begin
      flashCnt <= flashCnt + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      screen_pkg::ST_INIT: begin
        if (syncReady) begin
          if (!inClosed) begin
            state_next = screen_pkg::ST_LOCKOUT;
          end else if (ctrl_reg[screen_pkg::CTRL_LATCH]) begin
            state_next = screen_pkg::ST_LATCH;
          end else begin
            state_next = screen_pkg::ST_RUN;
          end
        end
      end
      screen_pkg::ST_LOCKOUT, screen_pkg::ST_LATCH: begin
        // Operating the input here is a reset request only
        if (releasePulse) begin
          state_next = screen_pkg::ST_RUN;
        end
      end
      screen_pkg::ST_RUN: begin
        if (openQuarter || testReq_reg) begin
          state_next = screen_pkg::ST_TEST;
        end else if (ctrl_reg[screen_pkg::CTRL_MON] && openMon) begin
          state_next = screen_pkg::ST_TEST;
        end else if (ctrl_reg[screen_pkg::CTRL_LATCH] && !fieldClear) begin
          state_next = screen_pkg::ST_LATCH;
        end
      end
      screen_pkg::ST_TEST: begin
        // Hold the test while the input is still open
        if (testCnt == '0 && inClosed) begin
          state_next = screen_pkg::ST_RUN;
        end
      end
    endcase
    if (lockReq_reg && state_reg != screen_pkg::ST_INIT) begin
      state_next = screen_pkg::ST_LOCKOUT;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= screen_pkg::ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Self-test length counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      testCnt <= '0;
    end else if (state_reg != screen_pkg::ST_TEST) begin
      testCnt <= CNT_W'(TEST_CYC - 1);
    end else if (testCnt != '0) begin
      testCnt <= testCnt - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Safety outputs: on only in run with a clear field
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      safetySwitchingOutputs <= 2'h0;
    end else if (state_reg == screen_pkg::ST_RUN && fieldClear) begin
      safetySwitchingOutputs <= 2'h3;
    end else begin
      safetySwitchingOutputs <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      leds <= '0;
    end else begin
      unique case (state_reg)
        screen_pkg::ST_INIT: begin
          leds <= '0;
        end
        screen_pkg::ST_LOCKOUT: begin
          leds <= '{alignTop: 1'b0, alignBot: 1'b0,
                    blocked: flashPhase, clear: 1'b0};
        end
        screen_pkg::ST_LATCH: begin
          if (fieldClear) begin
            leds <= '{alignTop: flashPhase, alignBot: flashPhase,
                      blocked: 1'b1, clear: 1'b0};
          end else begin
            leds <= '{alignTop: beamTopClear, alignBot: beamBotClear,
                      blocked: 1'b1, clear: 1'b0};
          end
        end
        screen_pkg::ST_RUN: begin
          leds <= '{alignTop: beamTopClear, alignBot: beamBotClear,
                    blocked: !fieldClear, clear: fieldClear};
        end
        screen_pkg::ST_TEST: begin
          // Green flashes with red on while testing
          leds <= '{alignTop: beamTopClear, alignBot: beamBotClear,
                    blocked: 1'b1, clear: flashPhase};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and one-shot commands
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= screen_pkg::CTRL_RST;
      testReq_reg <= 1'b0;
      lockReq_reg <= 1'b0;
    end else begin
      testReq_reg <= 1'b0;
      lockReq_reg <= 1'b0;
      if (wrAccess && paddr == screen_pkg::OFF_CTRL) begin
        ctrl_reg    <= pwdata[1:0];
        testReq_reg <= pwdata[screen_pkg::CTRL_TEST];
        lockReq_reg <= pwdata[screen_pkg::CTRL_LOCK];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: sticky, read-clear, set wins over clear
  // ----------------------------------------------------------------
  assign events[screen_pkg::INT_TEST] = state_next == screen_pkg::ST_TEST &&
                                        state_reg != screen_pkg::ST_TEST;
  assign events[screen_pkg::INT_LOCKOUT] = state_next == screen_pkg::ST_LOCKOUT &&
                                           state_reg != screen_pkg::ST_LOCKOUT;
  assign events[screen_pkg::INT_LATCH] = state_next == screen_pkg::ST_LATCH &&
                                         state_reg != screen_pkg::ST_LATCH;
  assign events[screen_pkg::INT_RESET] = releasePulse &&
                                         (state_reg == screen_pkg::ST_LATCH ||
                                          state_reg == screen_pkg::ST_LOCKOUT);
  assign rdStatAccess = accessPh && !pwrite && paddr == screen_pkg::OFF_INT_STAT;

  // Only bits already returned to software are cleared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intStat_reg <= screen_pkg::INT_RST;
    end else if (rdStatAccess) begin
      intStat_reg <= (intStat_reg & ~rdClear_reg) | events;
    end else begin
      intStat_reg <= intStat_reg | events;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intMask_reg <= screen_pkg::INT_RST;
    end else if (wrAccess && paddr == screen_pkg::OFF_INT_MASK) begin
      intMask_reg <= pwdata[screen_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_reg & intMask_reg);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, read data set up early
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      rdClear_reg <= '0;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped(paddr);
      if (setupPh && !pwrite) begin
        rdClear_reg <= intStat_reg;
        unique case (paddr)
          screen_pkg::OFF_CTRL:     prdata <= {30'h0, ctrl_reg};
          screen_pkg::OFF_STATUS:   prdata <= {24'h0, beamBotClear, beamTopClear,
                                               inClosed, safetySwitchingOutputs,
                                               state_reg};
          screen_pkg::OFF_INT_STAT: prdata <= {28'h0, intStat_reg};
          screen_pkg::OFF_INT_MASK: prdata <= {28'h0, intMask_reg};
          default:                  prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  outputs_only_run_a: assert property (
    (safetySwitchingOutputs != 2'h0) |-> $past(state_reg) == screen_pkg::ST_RUN)
    else $error("Outputs on outside run");
  quarter_test_a: assert property (
    (state_reg == screen_pkg::ST_RUN && openQuarter && !lockReq_reg)
    |=> state_reg == screen_pkg::ST_TEST ##1 safetySwitchingOutputs == 2'h0)
    else $error("Long open did not start test");
  monitor_test_a: assert property (
    (state_reg == screen_pkg::ST_RUN && ctrl_reg[screen_pkg::CTRL_MON] && openMon &&
     !lockReq_reg) |=> state_reg == screen_pkg::ST_TEST)
    else $error("Monitor open did not start test");
  lockout_flash_a: assert property (
    (state_reg == screen_pkg::ST_LOCKOUT)
    |=> leds.blocked == $past(flashPhase) && !leds.clear)
    else $error("Lockout lamp wrong");
  blocked_lamps_a: assert property (
    (state_reg == screen_pkg::ST_RUN && !fieldClear)
    |=> leds.blocked && !leds.clear && leds.alignTop == $past(beamTopClear))
    else $error("Blocked lamps wrong");
  clear_lamps_a: assert property (
    (state_reg == screen_pkg::ST_RUN && fieldClear)
    |=> leds == 4'hD && safetySwitchingOutputs == 2'h3)
    else $error("Clear lamps wrong");
  latch_lamps_a: assert property (
    (state_reg == screen_pkg::ST_LATCH && fieldClear)
    |=> leds.blocked && !leds.clear && leds.alignTop == $past(flashPhase))
    else $error("Latch lamps wrong");
  latch_hold_a: assert property (
    (state_reg == screen_pkg::ST_LATCH && !releasePulse)
    |=> state_reg inside {screen_pkg::ST_LATCH, screen_pkg::ST_LOCKOUT})
    else $error("Latch left without reset");
  no_test_lock_a: assert property (
    (state_reg == screen_pkg::ST_LOCKOUT) |=> state_reg != screen_pkg::ST_TEST)
    else $error("Test taken in lockout");
  powerup_lock_a: assert property (
    (state_reg == screen_pkg::ST_INIT && syncReady && !inClosed)
    |=> state_reg == screen_pkg::ST_LOCKOUT)
    else $error("Open input at power-up not locked out");
  latch_on_block_a: assert property (
    (state_reg == screen_pkg::ST_RUN && ctrl_reg[screen_pkg::CTRL_LATCH] &&
     !fieldClear && !openQuarter && !openMon && !testReq_reg && !lockReq_reg)
    |=> state_reg == screen_pkg::ST_LATCH)
    else $error("Latch unit did not latch");

  test_seen_c:  cover property (state_reg == screen_pkg::ST_TEST);
  reset_seen_c: cover property (events[screen_pkg::INT_RESET]);
  latch_seen_c: cover property (state_reg == screen_pkg::ST_LATCH && fieldClear);

endmodule

`default_nettype wire

// >>> verilog/screen_pkg.sv
// Shared constants, types and register map of the screen reset/test monitor
package screen_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL     = 4'h0;
  localparam logic [3:0] OFF_STATUS   = 4'h4;
  localparam logic [3:0] OFF_INT_STAT = 4'h8;
  localparam logic [3:0] OFF_INT_MASK = 4'hC;

  // Control register fields
  localparam int CTRL_LATCH = 0;
  localparam int CTRL_MON   = 1;
  localparam int CTRL_TEST  = 2;
  localparam int CTRL_LOCK  = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status register fields
  localparam int STAT_STATE = 0;
  localparam int STAT_OUT   = 3;
  localparam int STAT_IN    = 5;
  localparam int STAT_BEAM  = 6;

  // Interrupt event bits
  localparam int INT_W       = 4;
  localparam int INT_TEST    = 0;
  localparam int INT_LOCKOUT = 1;
  localparam int INT_LATCH   = 2;
  localparam int INT_RESET   = 3;
  localparam logic [INT_W-1:0] INT_RST = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 100000;
  localparam int QUARTER_MS   = 250;
  localparam int MON_MS       = 200;
  localparam int FLASH_MS     = 125;
  localparam int TEST_US      = 10;
  localparam int QUARTER_CYC  = QUARTER_MS * CLK_KHZ;
  localparam int MON_CYC      = MON_MS * CLK_KHZ;
  localparam int FLASH_CYC    = FLASH_MS * CLK_KHZ;
  localparam int TEST_CYC     = (TEST_US * CLK_KHZ) / 1000;
  localparam int SYNC_STAGES  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT, ST_LOCKOUT, ST_LATCH, ST_RUN, ST_TEST
  } state_e;

  typedef struct packed {
    logic alignTop;
    logic alignBot;
    logic blocked;
    logic clear;
  } led_s;

endpackage
